// *** inc/two_wire_pkg.sv ***
// Constants, types and carriers shared by the two-wire register slave.
package two_wire_pkg;

  // --------------------------------------------------------------------
  // Addresses and bit framing
  // --------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR_PIN_LOW = 7'h48;
  localparam logic [6:0] SLAVE_ADDR_PIN_HIGH = 7'h5d;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
  localparam logic [3:0] FIRST_BIT_TAKEN = 4'h1;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // --------------------------------------------------------------------
  // State encodings
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IGNORE = 3'b000,
    PH_ADDR = 3'b001,
    PH_AHI = 3'b010,
    PH_ALO = 3'b011,
    PH_DHI = 3'b100,
    PH_DLO = 3'b101,
    PH_RDA = 3'b110,
    PH_RD = 3'b111
  } link_phase_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WR = 2'b01,
    ST_CAP = 2'b10
  } xfer_state_e;

  localparam link_phase_e PHASE_RESET = PH_IGNORE;
  localparam xfer_state_e XFER_RESET = ST_WR;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [15:0] waddr;
    logic [15:0] wdata;
    logic [15:0] faddr;
  } link_req_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_port_s;

  localparam link_req_s LINK_REQ_RESET = '0;
  localparam reg_port_s REG_PORT_RESET = '0;

endpackage

// *** logic/bit_sync2.sv ***
// Two-stage synchroniser for levels and toggles entering a clock domain.
`timescale 1ns/1ns
module bit_sync2 #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // bit_sync2

// *** logic/two_wire_register_slave.sv ***
// Two-wire serial slave giving a master access to 16-bit device registers.
`timescale 1ns/1ns
module two_wire_register_slave
  import two_wire_pkg::*;
(
  // System clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Two-wire link
  input wire logic serial_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // Slave address selection
  input wire logic bus_address_select_pin,
  input wire logic addr_override_en,
  input wire logic [6:0] addr_override,
  // Register port towards the device
  output reg_port_s reg_port,
  input wire logic [15:0] reg_rdata,
  // Status
  output logic bus_busy
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic start_tgl_r;
  logic stop_tgl_r;
  logic start_seen_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  link_phase_e phase_r;
  logic [15:0] ptr_r;
  logic [7:0] data_hi_r;
  logic [7:0] tx_r;
  logic [7:0] lo_hold_r;
  logic lo_next_r;
  logic ack_pend_r;
  link_req_s req_r;
  logic req_tgl_r;
  logic [15:0] rd_word_r;
  logic ack_seen_r;
  logic [9:0] link_sync;
  logic ack_tgl_sync;
  logic pin_sync;
  logic ovr_en_sync;
  logic [6:0] ovr_sync;
  logic [6:0] cur_addr;
  logic [7:0] byte_in;
  logic new_start;
  logic addr_match;
  logic load_hi;
  xfer_state_e xfer_r;
  logic [15:0] faddr_r;
  logic req_seen_r;
  logic ack_tgl_r;
  logic [15:0] rdata_hold_r;
  logic [2:0] ref_sync;
  logic start_seen_ref_r;
  logic stop_seen_ref_r;

  // --------------------------------------------------------------------
  // Start and stop detection
  // --------------------------------------------------------------------
  // These flops are clocked by the data line itself, since a start or
  // stop happens while the serial clock stands high and gives no edge.
  always_ff @(negedge serial_data_in or negedge reset_n) begin
    if (!reset_n) begin
      start_tgl_r <= 1'b0;
    end else if (serial_clock) begin
      start_tgl_r <= ~start_tgl_r;
    end
  end

  always_ff @(posedge serial_data_in or negedge reset_n) begin
    if (!reset_n) begin
      stop_tgl_r <= 1'b0;
    end else if (serial_clock) begin
      stop_tgl_r <= ~stop_tgl_r;
    end
  end

  // --------------------------------------------------------------------
  // Crossings into the link domain
  // --------------------------------------------------------------------
  bit_sync2 #(.WIDTH(10)) u_link_sync (
    .clk(serial_clock),
    .reset_n(reset_n),
    .d({ack_tgl_r, bus_address_select_pin, addr_override_en,
        addr_override}),
    .q(link_sync)
  );

  assign ack_tgl_sync = link_sync[9];
  assign pin_sync = link_sync[8];
  assign ovr_en_sync = link_sync[7];
  assign ovr_sync = link_sync[6:0];

  // --------------------------------------------------------------------
  // Byte decode
  // --------------------------------------------------------------------
  always_comb begin
    cur_addr = pin_sync ? SLAVE_ADDR_PIN_HIGH : SLAVE_ADDR_PIN_LOW;
    if (ovr_en_sync) begin
      cur_addr = ovr_sync;
    end
  end

  assign byte_in = {shift_r[6:0], serial_data_in};
  assign new_start = start_tgl_r != start_seen_r;
  assign addr_match = byte_in[7:1] == cur_addr;
  assign load_hi = (phase_r == PH_RDA) ||
                   ((phase_r == PH_RD) && !serial_data_in && !lo_next_r);

  // --------------------------------------------------------------------
  // Link sequencer, sampling on the rising serial clock
  // --------------------------------------------------------------------
  // Data is only sampled on the rising edge, where it is stable.
  always_ff @(posedge serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      start_seen_r <= 1'b0;
      cnt_r <= BIT_COUNT_RESET;
      shift_r <= BYTE_RESET;
      phase_r <= PHASE_RESET;
      ptr_r <= PTR_RESET;
      data_hi_r <= BYTE_RESET;
      tx_r <= BYTE_RESET;
      lo_hold_r <= BYTE_RESET;
      lo_next_r <= 1'b0;
      ack_pend_r <= 1'b0;
      req_r <= LINK_REQ_RESET;
      req_tgl_r <= 1'b0;
    end else if (new_start) begin
      start_seen_r <= start_tgl_r;
      cnt_r <= FIRST_BIT_TAKEN;
      shift_r <= {7'h00, serial_data_in};
      phase_r <= PH_ADDR;
      ack_pend_r <= 1'b0;
    end else if (cnt_r < ACK_SLOT) begin
      shift_r <= byte_in;
      cnt_r <= cnt_r + 4'h1;
      ack_pend_r <= 1'b0;
      if (cnt_r == LAST_DATA_BIT) begin
        case (phase_r)
          PH_ADDR: begin
            if (addr_match) begin
              ack_pend_r <= 1'b1;
              phase_r <= (byte_in[0] == DIR_WRITE) ? PH_AHI : PH_RDA;
            end else begin
              phase_r <= PH_IGNORE;
            end
          end
          PH_AHI: begin
            ptr_r[15:8] <= byte_in;
            ack_pend_r <= 1'b1;
            phase_r <= PH_ALO;
          end
          PH_ALO: begin
            ptr_r[7:0] <= byte_in;
            ack_pend_r <= 1'b1;
            req_r.wr <= 1'b0;
            req_r.faddr <= {ptr_r[15:8], byte_in};
            req_tgl_r <= ~req_tgl_r;
            phase_r <= PH_DHI;
          end
          PH_DHI: begin
            data_hi_r <= byte_in;
            ack_pend_r <= 1'b1;
            phase_r <= PH_DLO;
          end
          PH_DLO: begin
            ack_pend_r <= 1'b1;
            req_r.wr <= 1'b1;
            req_r.waddr <= ptr_r;
            req_r.wdata <= {data_hi_r, byte_in};
            req_r.faddr <= ptr_r + PTR_STEP;
            req_tgl_r <= ~req_tgl_r;
            ptr_r <= ptr_r + PTR_STEP;
            phase_r <= PH_DHI;
          end
          default: begin
          end
        endcase
      end
    end else begin
      cnt_r <= BIT_COUNT_RESET;
      ack_pend_r <= 1'b0;
      if (phase_r == PH_RD && serial_data_in) begin
        phase_r <= PH_IGNORE;
      end else if (load_hi) begin
        // The low byte is held now, so the next word can be fetched
        // during this whole pair without disturbing it.
        tx_r <= rd_word_r[15:8];
        lo_hold_r <= rd_word_r[7:0];
        lo_next_r <= 1'b1;
        phase_r <= PH_RD;
        req_r.wr <= 1'b0;
        req_r.faddr <= ptr_r + PTR_STEP;
        req_tgl_r <= ~req_tgl_r;
        ptr_r <= ptr_r + PTR_STEP;
      end else if (phase_r == PH_RD) begin
        tx_r <= lo_hold_r;
        lo_next_r <= 1'b0;
      end
    end
  end

  // Fetched words arrive by toggle; the held word is stable by then.
  always_ff @(posedge serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_seen_r <= 1'b0;
      rd_word_r <= WORD_RESET;
    end else if (ack_tgl_sync != ack_seen_r) begin
      ack_seen_r <= ack_tgl_sync;
      rd_word_r <= rdata_hold_r;
    end
  end

  // --------------------------------------------------------------------
  // Data line drive, changed on the falling serial clock
  // --------------------------------------------------------------------
  // The slave only ever pulls low between clock edges, so it can never
  // form a start or stop of its own.
  always_ff @(negedge serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      serial_data_oe <= 1'b0;
    end else if (new_start) begin
      serial_data_oe <= 1'b0;
    end else if (cnt_r == ACK_SLOT) begin
      serial_data_oe <= ack_pend_r;
    end else if (phase_r == PH_RD) begin
      serial_data_oe <= ~tx_r[~cnt_r[2:0]];
    end else begin
      serial_data_oe <= 1'b0;
    end
  end

  // The pad only ever pulls low; its level is set by the enable alone.
  always_ff @(negedge serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      serial_data_out <= 1'b0;
    end else begin
      serial_data_out <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Crossings into the system domain
  // --------------------------------------------------------------------
  bit_sync2 #(.WIDTH(3)) u_ref_sync (
    .clk(ref_clk),
    .reset_n(reset_n),
    .d({req_tgl_r, start_tgl_r, stop_tgl_r}),
    .q(ref_sync)
  );

  // --------------------------------------------------------------------
  // Register access sequencer
  // --------------------------------------------------------------------
  // Every request writes first when asked, then reads the next pointer
  // word. Starting in the write step after reset fetches word 0, so a
  // read from the current location works before any address is sent.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      xfer_r <= XFER_RESET;
      reg_port <= REG_PORT_RESET;
      faddr_r <= PTR_RESET;
      req_seen_r <= 1'b0;
      ack_tgl_r <= 1'b0;
      rdata_hold_r <= WORD_RESET;
    end else begin
      case (xfer_r)
        ST_IDLE: begin
          reg_port.wr <= 1'b0;
          reg_port.rd <= 1'b0;
          if (ref_sync[2] != req_seen_r) begin
            req_seen_r <= ref_sync[2];
            faddr_r <= req_r.faddr;
            if (req_r.wr) begin
              reg_port.wr <= 1'b1;
              reg_port.addr <= req_r.waddr;
              reg_port.wdata <= req_r.wdata;
              xfer_r <= ST_WR;
            end else begin
              reg_port.rd <= 1'b1;
              reg_port.addr <= req_r.faddr;
              xfer_r <= ST_CAP;
            end
          end
        end
        ST_WR: begin
          reg_port.wr <= 1'b0;
          reg_port.rd <= 1'b1;
          reg_port.addr <= faddr_r;
          xfer_r <= ST_CAP;
        end
        ST_CAP: begin
          reg_port.rd <= 1'b0;
          rdata_hold_r <= reg_rdata;
          ack_tgl_r <= ~ack_tgl_r;
          xfer_r <= ST_IDLE;
        end
        default: begin
          reg_port.wr <= 1'b0;
          reg_port.rd <= 1'b0;
          xfer_r <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Bus busy status
  // --------------------------------------------------------------------
  // A start seen in the same cycle as a stop wins, as it came later.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_seen_ref_r <= 1'b0;
      stop_seen_ref_r <= 1'b0;
      bus_busy <= 1'b0;
    end else begin
      start_seen_ref_r <= ref_sync[1];
      stop_seen_ref_r <= ref_sync[0];
      if (ref_sync[1] != start_seen_ref_r) begin
        bus_busy <= 1'b1;
      end else if (ref_sync[0] != stop_seen_ref_r) begin
        bus_busy <= 1'b0;
      end
    end
  end

endmodule // two_wire_register_slave

// *** dv/two_wire_host_model.sv ***
// Behavioural two-wire bus master that frames bytes for the slave.
`timescale 1ns/1ns
module two_wire_host_model (
  // Wire levels
  output logic scl,
  output logic sda_drv_n,
  input wire logic sda
);
  // The 30 ns link clock stands high between frames.
  initial begin
    scl = 1'b1;
    sda_drv_n = 1'b1;
  end
  task automatic start();
    #2 sda_drv_n = 1'b1;
    #13 scl = 1'b1;
    #15 sda_drv_n = 1'b0;
    #15 scl = 1'b0;
  endtask
  task automatic stop();
    #2 sda_drv_n = 1'b0;
    #13 scl = 1'b1;
    #15 sda_drv_n = 1'b1;
    #15;
  endtask
  // Data moves 2 ns after the clock falls, so no bit looks like a start.
  task automatic put_byte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #2 sda_drv_n = v[i];
      #13 scl = 1'b1;
      #15 scl = 1'b0;
    end
    #2 sda_drv_n = 1'b1;
    #13 scl = 1'b1;
    #15 ack = ~sda;
    scl = 1'b0;
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      #2 sda_drv_n = 1'b1;
      #13 scl = 1'b1;
      #15 v[i] = sda;
      scl = 1'b0;
    end
    #2 sda_drv_n = nack;
    #13 scl = 1'b1;
    #15 scl = 1'b0;
  endtask
endmodule // two_wire_host_model

// *** dv/two_wire_slave_sva.sv ***
// Concurrent checks on the ports of the two-wire register slave.
`timescale 1ns/1ns
module two_wire_slave_sva
  import two_wire_pkg::*;
(
  // System clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Two-wire link
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  // Address selection
  input wire logic bus_address_select_pin,
  input wire logic addr_override_en,
  input wire logic [6:0] addr_override,
  // Register port and status
  input wire reg_port_s reg_port,
  input wire logic [15:0] reg_rdata,
  input wire logic bus_busy
);
  // The drive level seen at each rising link edge must last the high phase.
  logic oe_at_rise;
  always_ff @(posedge serial_clock or negedge reset_n) begin
    if (!reset_n) oe_at_rise <= 1'b0;
    else oe_at_rise <= serial_data_oe;
  end
  sequence s_next_fetch;
    ##1 reg_port.rd && !reg_port.wr &&
      reg_port.addr == $past(reg_port.addr) + PTR_STEP;
  endsequence
  sequence s_no_write4;
    !reg_port.wr [*4];
  endsequence
  a_oe_steady_high: assert property (
    @(negedge serial_clock) disable iff (!reset_n)
    serial_data_oe == oe_at_rise) else $error("drive moved in high phase");
  a_out_pulls_low: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    serial_data_oe |-> !serial_data_out) else $error("drive not low");
  a_idle_released: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !bus_busy |-> !serial_data_oe) else $error("drive on idle bus");
  a_wr_then_fetch: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    reg_port.wr |-> s_next_fetch) else $error("no fetch of next word");
  a_wr_single: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    reg_port.wr |=> !reg_port.wr) else $error("write pulse too long");
  a_rd_single: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    reg_port.rd |=> !reg_port.rd) else $error("read pulse too long");
  a_req_spacing: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $fell(reg_port.rd) |-> s_no_write4) else $error("requests too close");
  a_port_holds: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !reg_port.wr && !reg_port.rd |-> $stable(reg_port.addr) &&
    $stable(reg_port.wdata)) else $error("port moved between requests");
endmodule // two_wire_slave_sva

// *** dv/tb.sv ***
// Self-checking testbench for the two-wire register slave.
`timescale 1ns/1ns
module tb;
  import two_wire_pkg::*;
  logic ref_clk = 1'b0;
  // Starts high so that the first assertion is a real falling edge; the
  // link-side flops only clear on that edge, as the link clock is idle.
  logic reset_n = 1'b1;
  logic pin_sel = 1'b0;
  logic ovr_en = 1'b0;
  logic [6:0] ovr = 7'h21;
  logic scl, host_sda_n, sda, dout, oe, busy, ack;
  logic [7:0] b;
  reg_port_s rp;
  logic [15:0] mem [16];
  logic [15:0] rdata;
  int failures = 0;
  int samples_checked = 0;
  always #20 ref_clk = ~ref_clk;
  // Pull-up on the data wire; any party driving wins low.
  assign sda = host_sda_n & ~oe;
  assign rdata = mem[rp.addr[3:0]];
  always @(posedge ref_clk) if (rp.wr) mem[rp.addr[3:0]] <= rp.wdata;
  two_wire_register_slave i_two_wire_register_slave (
    .ref_clk(ref_clk), .reset_n(reset_n), .serial_clock(scl),
    .serial_data_in(sda), .serial_data_out(dout), .serial_data_oe(oe),
    .bus_address_select_pin(pin_sel), .addr_override_en(ovr_en),
    .addr_override(ovr), .reg_port(rp), .reg_rdata(rdata), .bus_busy(busy));
  two_wire_host_model host (.scl(scl), .sda_drv_n(host_sda_n), .sda(sda));
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] v, input logic exp_ack);
    host.put_byte(v, ack);
    check("ack", {15'h0, ack}, {15'h0, exp_ack});
  endtask
  task automatic get(input logic nack, input logic [7:0] exp);
    host.get_byte(nack, b);
    check("read byte", {8'h0, b}, {8'h0, exp});
  endtask
  task automatic frame(input logic [7:0] a, input logic exp_ack);
    host.start();
    send(a, exp_ack);
    host.stop();
  endtask
  // Two words from address 3, then a pair cut short after its high byte.
  task automatic sc_write();
    host.start();
    send(8'h90, 1'b1);
    send(8'h00, 1'b1);
    send(8'h03, 1'b1);
    send(8'ha5, 1'b1);
    send(8'h3c, 1'b1);
    send(8'h0f, 1'b1);
    send(8'h1e, 1'b1);
    send(8'h77, 1'b1);
  endtask
  task automatic sc_read_random();
    host.start();
    send(8'h90, 1'b1);
    send(8'h00, 1'b1);
    send(8'h03, 1'b1);
    host.start();
    send(8'h91, 1'b1);
    get(1'b0, 8'ha5);
    get(1'b0, 8'h3c);
    get(1'b0, 8'h0f);
    get(1'b1, 8'h1e);
    check("busy", {15'h0, busy}, 16'h1);
    check("data out", {15'h0, dout}, 16'h0);
    host.stop();
    repeat (8) @(negedge ref_clk);
    check("busy", {15'h0, busy}, 16'h0);
    check("reg 3", mem[3], 16'ha53c);
    check("reg 4", mem[4], 16'h0f1e);
    check("reg 5", mem[5], 16'hc005);
  endtask
  task automatic sc_read_current();
    host.start();
    send(8'h91, 1'b1);
    get(1'b0, 8'hc0);
    get(1'b1, 8'h05);
    host.stop();
  endtask
  task automatic sc_address();
    host.start();
    send(8'hba, 1'b0);
    send(8'h00, 1'b0);
    host.stop();
    @(negedge ref_clk) pin_sel = 1'b1;
    repeat (4) @(negedge ref_clk);
    host.start();
    send(8'hba, 1'b1);
    host.start();
    send(8'hbb, 1'b1);
    get(1'b1, 8'hc0);
    host.stop();
    frame(8'h90, 1'b0);
    @(negedge ref_clk) ovr_en = 1'b1;
    repeat (4) @(negedge ref_clk);
    frame(8'h42, 1'b1);
    frame(8'hba, 1'b0);
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hc000 + 16'(i);
    #1 reset_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    #7;
    sc_write();
    sc_read_random();
    sc_read_current();
    sc_address();
    test_done();
  end
  // The scenarios need about 9 us; a hang is cut well beyond that.
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule // tb
bind two_wire_register_slave two_wire_slave_sva u_sva (
  .ref_clk(ref_clk), .reset_n(reset_n), .serial_clock(serial_clock),
  .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
  .serial_data_oe(serial_data_oe),
  .bus_address_select_pin(bus_address_select_pin),
  .addr_override_en(addr_override_en), .addr_override(addr_override),
  .reg_port(reg_port), .reg_rdata(reg_rdata), .bus_busy(bus_busy));
